/* src/dpit_cfg.svh */
`ifndef DPIT_CFG_SVH
`define DPIT_CFG_SVH
// Notes on behaviour
// - Target works at Standard and Fast mode bus speeds.
// - Start is SDA falling with SCL high; device detects it and begins.
// - Address byte arrives MSB first, direction bit last; shifted in that order.
// - On a matching address the device holds SDA low over the acknowledge high.
// - SDA changes only while SCL low; changes while high are Start or Stop.
// - Stop is SDA rising with SCL high; device detects it and goes idle.
// - Any number of bytes, each eight bits plus exactly one acknowledge bit.
// - Transmitter releases SDA after the eighth bit for the acknowledge.
// - Addressed for write, the device acknowledges every received byte.
// - On a read not acknowledged the device stops sending and releases SDA.
// - Device may hold SCL low around a byte while it is not ready.
// - Stretching may hit any clock pulse; master checks every pulse.
// - Two addresses per interface; first reaches port 1, second port 2.
// - Addresses set during boot; no bus response before that is done.
// - First interface derives both port addresses from the decoded strap.
// - Address byte bits 7 to 1 hold address, bit 0 the direction.
// - Every address bit of each port can be overridden by firmware.
// - Second interface uses fixed per-port addresses, not the strap.
// - First interface may act as master too; second is target only. Here master_mode_i only parks the first target; there is no master logic.
// - Decoded strap level supplies address byte bits 2 to 1.

`define DPIT_CLK_NS     40
`define DPIT_BOOT_NS    1000
`define DPIT_BOOT_CYC   ((`DPIT_BOOT_NS + `DPIT_CLK_NS - 1) / `DPIT_CLK_NS)
`define DPIT_BYTE_BITS  4'h8
`define DPIT_P1_BASE    7'h20
`define DPIT_P2_BASE    7'h24
`define DPIT_FIX_P1     7'h38
`define DPIT_FIX_P2     7'h3F
`endif

/* src/dpit_pkg.sv */
package dpit_pkg;
  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_RX, L_TX, L_MACK, L_WAIT, L_ACK, L_IGNORE
  } dpit_lstate_t;

  typedef enum logic [1:0] {
    EV_ADDR_WR, EV_ADDR_RD, EV_DATA_WR, EV_DATA_RD
  } dpit_kind_t;

  typedef struct packed {
    dpit_lstate_t st;
    logic [7:0]   shift;
    logic [3:0]   cnt;
    logic         rw;
    logic         port;
    logic         sda_oe;
    logic         scl_oe;
    logic         ack_got;
    logic         scl_q;
    logic         sda_q;
    logic         ack_q;
    logic         evt_tgl;
    logic         stop_tgl;
    dpit_kind_t   kind;
    logic [7:0]   evt_data;
    logic [6:0]   adr1;
    logic [6:0]   adr2;
    logic         addr_ok;
    logic         addr_ack_tgl;
  } dpit_link_t;

  typedef struct packed {
    logic [7:0]   boot_cnt;
    logic         booted;
    logic [1:0]   strap;
    logic [6:0]   adr1;
    logic [6:0]   adr2;
    logic         adr_sent;
    logic         adr_tgl;
    logic         evt_q;
    logic         stop_q;
    logic         pend_wr;
    logic         resp_tgl;
    logic [7:0]   resp_data;
    logic         rx_valid;
    dpit_kind_t   rx_kind;
    logic [7:0]   rx_data;
    logic         rx_port;
    logic         tx_req;
    logic         stop_pulse;
  } dpit_core_t;
endpackage

/* src/dpit_sync.sv */
`timescale 1ns/1ns
module dpit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dpit_sync_st_t;

  dpit_sync_st_t s_reg;
  dpit_sync_st_t s_next;

  // Stage one feeds stage two only
  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d_i;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign q_o = s_reg.s2;
endmodule

/* src/dpit_top.sv */
`timescale 1ns/1ns
`include "dpit_cfg.svh"
module dpit_top #(
  parameter bit SECOND_TARGET_PORT = 1'b0
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       link_clk_i,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  input  wire logic [1:0] address_select_analog_pin_i,
  input  wire logic       master_mode_i,
  input  wire logic [6:0] addr_mask_p1_i,
  input  wire logic [6:0] addr_ovr_p1_i,
  input  wire logic [6:0] addr_mask_p2_i,
  input  wire logic [6:0] addr_ovr_p2_i,
  input  wire logic       rx_ready_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            booted_o,
  output logic            rx_valid_o,
  output logic [1:0]      rx_kind_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_port_o,
  output logic            tx_req_o,
  output logic            stop_o
);
  dpit_pkg::dpit_link_t l_reg;
  dpit_pkg::dpit_link_t l_next;
  dpit_pkg::dpit_core_t c_reg;
  dpit_pkg::dpit_core_t c_next;

  logic       link_rst_b;
  logic [4:0] ls;
  logic [4:0] cs;
  logic       scl_s;
  logic       sda_s;
  logic       mm_s;
  logic       ack_s;
  logic       adr_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       ack_edge;
  logic       active;
  logic       hit1;
  logic       hit2;
  logic [6:0] base1;
  logic [6:0] base2;
  logic [6:0] hw1;
  logic [6:0] hw2;
  logic [6:0] eff1;
  logic [6:0] eff2;

  // Reset reaches the link domain through its own synchroniser
  dpit_sync #(.W(1)) u_rst_sync (
    .clk_i (link_clk_i),
    .d_i   (rst_b_i),
    .q_o   (link_rst_b)
  );

  // Pins oversampled by the 30 ns link clock keep Fast mode margins
  dpit_sync #(.W(5)) u_link_sync (
    .clk_i (link_clk_i),
    .d_i   ({scl_i, sda_i, master_mode_i, c_reg.resp_tgl, c_reg.adr_tgl}),
    .q_o   (ls)
  );

  // Strap is static after power-up, so a plain two-stage catch is enough
  dpit_sync #(.W(5)) u_core_sync (
    .clk_i (core_clk_i),
    .d_i   ({address_select_analog_pin_i, l_reg.evt_tgl, l_reg.stop_tgl,
             l_reg.addr_ack_tgl}),
    .q_o   (cs)
  );

  assign scl_s    = ls[4];
  assign sda_s    = ls[3];
  assign mm_s     = ls[2];
  assign ack_s    = ls[1];
  assign adr_s    = ls[0];
  assign scl_rise = scl_s & ~l_reg.scl_q;
  assign scl_fall = ~scl_s & l_reg.scl_q;
  assign start_ev = l_reg.scl_q & scl_s & l_reg.sda_q & ~sda_s;
  assign stop_ev  = l_reg.scl_q & scl_s & ~l_reg.sda_q & sda_s;
  assign ack_edge = ack_s ^ l_reg.ack_q;
  // Master role of the first interface parks the target
  assign active   = l_reg.addr_ok & (SECOND_TARGET_PORT | ~mm_s);
  assign hit1     = l_reg.shift[7:1] == l_reg.adr1;
  assign hit2     = l_reg.shift[7:1] == l_reg.adr2;

  assign base1 = `DPIT_P1_BASE;
  assign base2 = `DPIT_P2_BASE;
  // Strap level lands in byte bits 2:1
  assign hw1   = SECOND_TARGET_PORT ? `DPIT_FIX_P1 : {base1[6:2], c_reg.strap};
  assign hw2   = SECOND_TARGET_PORT ? `DPIT_FIX_P2 : {base2[6:2], c_reg.strap};
  assign eff1  = (hw1 & ~addr_mask_p1_i) | (addr_ovr_p1_i & addr_mask_p1_i);
  assign eff2  = (hw2 & ~addr_mask_p2_i) | (addr_ovr_p2_i & addr_mask_p2_i);

  // Link domain: bit engine on the pins
  always_comb begin
    l_next       = l_reg;
    l_next.scl_q = scl_s;
    l_next.sda_q = sda_s;
    l_next.ack_q = ack_s;
    // Address words are held by the core until this echo returns
    if (adr_s != l_reg.addr_ack_tgl) begin
      l_next.adr1         = c_reg.adr1;
      l_next.adr2         = c_reg.adr2;
      l_next.addr_ok      = 1'b1;
      l_next.addr_ack_tgl = adr_s;
    end
    if (!active) begin
      l_next.st     = dpit_pkg::L_IDLE;
      l_next.sda_oe = 1'b0;
      l_next.scl_oe = 1'b0;
    end else if (stop_ev) begin
      if (l_reg.st != dpit_pkg::L_IDLE) begin
        l_next.stop_tgl = ~l_reg.stop_tgl;
      end
      l_next.st     = dpit_pkg::L_IDLE;
      l_next.sda_oe = 1'b0;
      l_next.scl_oe = 1'b0;
    end else if (start_ev) begin
      l_next.st     = dpit_pkg::L_ADDR;
      l_next.cnt    = 4'h0;
      l_next.sda_oe = 1'b0;
      l_next.scl_oe = 1'b0;
    end else begin
      case (l_reg.st)
        dpit_pkg::L_ADDR, dpit_pkg::L_RX: begin
          if (scl_rise) begin
            l_next.shift = {l_reg.shift[6:0], sda_s};
            l_next.cnt   = l_reg.cnt + 4'h1;
          end
          if (scl_fall && l_reg.cnt == `DPIT_BYTE_BITS) begin
            l_next.cnt     = 4'h0;
            l_next.ack_got = 1'b0;
            l_next.evt_data = l_reg.shift;
            if (l_reg.st == dpit_pkg::L_RX) begin
              l_next.kind    = dpit_pkg::EV_DATA_WR;
              l_next.evt_tgl = ~l_reg.evt_tgl;
              l_next.sda_oe  = 1'b1;
              l_next.st      = dpit_pkg::L_WAIT;
            end else if (hit1 || hit2) begin
              l_next.port    = ~hit1;
              l_next.rw      = l_reg.shift[0];
              l_next.kind    = l_reg.shift[0] ? dpit_pkg::EV_ADDR_RD : dpit_pkg::EV_ADDR_WR;
              l_next.evt_tgl = ~l_reg.evt_tgl;
              l_next.sda_oe  = 1'b1;
              l_next.st      = dpit_pkg::L_WAIT;
            end else begin
              l_next.st = dpit_pkg::L_IGNORE;
            end
          end
        end
        dpit_pkg::L_WAIT: begin
          if (ack_edge) begin
            l_next.ack_got = 1'b1;
          end
          // Leave only with SCL low so SDA never moves under a high clock
          if ((l_reg.ack_got || ack_edge) && !scl_s) begin
            l_next.scl_oe = 1'b0;
            if (l_reg.kind == dpit_pkg::EV_DATA_RD) begin
              l_next.shift  = c_reg.resp_data;
              l_next.sda_oe = ~c_reg.resp_data[7];
              l_next.cnt    = 4'h0;
              l_next.st     = dpit_pkg::L_TX;
            end else begin
              l_next.st = dpit_pkg::L_ACK;
            end
          end else if (!scl_s) begin
            l_next.scl_oe = 1'b1;
          end
        end
        dpit_pkg::L_ACK: begin
          if (scl_fall) begin
            l_next.cnt = 4'h0;
            if (l_reg.rw) begin
              l_next.shift  = c_reg.resp_data;
              l_next.sda_oe = ~c_reg.resp_data[7];
              l_next.st     = dpit_pkg::L_TX;
            end else begin
              l_next.sda_oe = 1'b0;
              l_next.st     = dpit_pkg::L_RX;
            end
          end
        end
        dpit_pkg::L_TX: begin
          if (scl_rise) begin
            l_next.cnt = l_reg.cnt + 4'h1;
          end
          if (scl_fall) begin
            if (l_reg.cnt == `DPIT_BYTE_BITS) begin
              l_next.sda_oe = 1'b0;
              l_next.st     = dpit_pkg::L_MACK;
            end else begin
              l_next.shift  = {l_reg.shift[6:0], 1'b0};
              l_next.sda_oe = ~l_reg.shift[6];
            end
          end
        end
        dpit_pkg::L_MACK: begin
          if (scl_rise) begin
            if (!sda_s) begin
              l_next.kind    = dpit_pkg::EV_DATA_RD;
              l_next.evt_tgl = ~l_reg.evt_tgl;
              l_next.ack_got = 1'b0;
              l_next.st      = dpit_pkg::L_WAIT;
            end else begin
              l_next.st = dpit_pkg::L_IGNORE;
            end
          end
        end
        dpit_pkg::L_IDLE, dpit_pkg::L_IGNORE: begin
          l_next.sda_oe = 1'b0;
          l_next.scl_oe = 1'b0;
        end
        default: begin
          l_next.st = dpit_pkg::L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rst_b) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // Core domain: boot, address hand-over, user handshake
  always_comb begin
    c_next            = c_reg;
    c_next.rx_valid   = 1'b0;
    c_next.stop_pulse = 1'b0;
    if (!c_reg.booted) begin
      c_next.boot_cnt = c_reg.boot_cnt + 8'h01;
      if (c_reg.boot_cnt == 8'(`DPIT_BOOT_CYC - 1)) begin
        c_next.booted = 1'b1;
        c_next.strap  = cs[4:3];
      end
    end else if (cs[0] == c_reg.adr_tgl &&
                 (!c_reg.adr_sent || eff1 != c_reg.adr1 || eff2 != c_reg.adr2)) begin
      c_next.adr1     = eff1;
      c_next.adr2     = eff2;
      c_next.adr_sent = 1'b1;
      c_next.adr_tgl  = ~c_reg.adr_tgl;
    end
    if (cs[2] != c_reg.evt_q) begin
      c_next.evt_q    = cs[2];
      c_next.rx_valid = 1'b1;
      c_next.rx_kind  = l_reg.kind;
      c_next.rx_data  = l_reg.evt_data;
      c_next.rx_port  = l_reg.port;
      if (l_reg.kind == dpit_pkg::EV_ADDR_RD || l_reg.kind == dpit_pkg::EV_DATA_RD) begin
        c_next.tx_req = 1'b1;
      end else begin
        c_next.pend_wr = 1'b1;
      end
    end else if (c_reg.pend_wr && rx_ready_i) begin
      c_next.pend_wr  = 1'b0;
      c_next.resp_tgl = ~c_reg.resp_tgl;
    end else if (c_reg.tx_req && tx_valid_i) begin
      c_next.tx_req    = 1'b0;
      c_next.resp_data = tx_data_i;
      c_next.resp_tgl  = ~c_reg.resp_tgl;
    end
    // A Stop cancels whatever answer is still owed
    if (cs[1] != c_reg.stop_q) begin
      c_next.stop_q     = cs[1];
      c_next.stop_pulse = 1'b1;
      c_next.pend_wr    = 1'b0;
      c_next.tx_req     = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign scl_oe_o   = l_reg.scl_oe;
  assign sda_oe_o   = l_reg.sda_oe;
  assign booted_o   = c_reg.booted;
  assign rx_valid_o = c_reg.rx_valid;
  assign rx_kind_o  = c_reg.rx_kind;
  assign rx_data_o  = c_reg.rx_data;
  assign rx_port_o  = c_reg.rx_port;
  assign tx_req_o   = c_reg.tx_req;
  assign stop_o     = c_reg.stop_pulse;

  sequence s_released;
    !l_reg.sda_oe [*2];
  endsequence

  sequence s_ack_low;
    l_reg.sda_oe && l_reg.st == dpit_pkg::L_WAIT;
  endsequence

  property p_start_addr;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      (active && start_ev && !stop_ev) |=> (l_reg.st == dpit_pkg::L_ADDR && l_reg.cnt == 4'h0);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_stop_idle;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      stop_ev |=> (l_reg.st == dpit_pkg::L_IDLE && !l_reg.scl_oe) ##0 s_released;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  property p_msb_first;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      (active && !start_ev && !stop_ev && scl_rise &&
       (l_reg.st == dpit_pkg::L_ADDR || l_reg.st == dpit_pkg::L_RX))
      |=> l_reg.shift[7:1] == $past(l_reg.shift[6:0]) && l_reg.shift[0] == $past(sda_s);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order wrong");

  property p_sda_low_scl;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      $changed(l_reg.sda_oe) |-> (!$past(scl_s) || !$past(active) ||
                                  $past(start_ev) || $past(stop_ev));
  endproperty
  a_sda_low_scl: assert property (p_sda_low_scl) else $error("SDA moved under high SCL");

  property p_no_boot_quiet;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      !l_reg.addr_ok |=> !l_reg.sda_oe && !l_reg.scl_oe;
  endproperty
  a_no_boot_quiet: assert property (p_no_boot_quiet) else $error("answered before boot");

  property p_addr_ack;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      (active && !start_ev && !stop_ev && scl_fall && l_reg.st == dpit_pkg::L_ADDR &&
       l_reg.cnt == `DPIT_BYTE_BITS && (hit1 || hit2))
      |=> s_ack_low ##0 (l_reg.port == !$past(hit1));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked");

  property p_addr_ignore;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      (active && !start_ev && !stop_ev && scl_fall && l_reg.st == dpit_pkg::L_ADDR &&
       l_reg.cnt == `DPIT_BYTE_BITS && !hit1 && !hit2)
      |=> l_reg.st == dpit_pkg::L_IGNORE ##0 s_released;
  endproperty
  a_addr_ignore: assert property (p_addr_ignore) else $error("foreign address acked");

  property p_wr_ack;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      (active && !start_ev && !stop_ev && scl_fall && l_reg.st == dpit_pkg::L_RX &&
       l_reg.cnt == `DPIT_BYTE_BITS) |=> s_ack_low;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acked");

  property p_nack_release;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      (active && !start_ev && !stop_ev && l_reg.st == dpit_pkg::L_MACK && scl_rise && sda_s)
      |=> l_reg.st == dpit_pkg::L_IGNORE ##0 s_released;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("no release after NACK");

  property p_stretch;
    @(posedge link_clk_i) disable iff (!link_rst_b)
      (active && !start_ev && !stop_ev && l_reg.st == dpit_pkg::L_WAIT &&
       !l_reg.ack_got && !ack_edge && !scl_s) |=> l_reg.scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("SCL not held while waiting");
endmodule

/* tb/dpit_master_model.sv */
`timescale 1ns/1ns
module dpit_master_model (
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      scl_drv_o,
  output logic      sda_drv_o
);
  int half_ns  = 1250;
  int hold_ns  = 4000;
  int timeouts = 0;

  initial begin
    scl_drv_o = 1'b1;
    sda_drv_o = 1'b1;
  end

  // Bounded wait, so a target that never lets go cannot hang the run
  task automatic scl_high();
    int n;
    n = 0;
    scl_drv_o = 1'b1;
    while (scl_i !== 1'b1 && n < 5000) begin
      #10;
      n++;
    end
    if (n >= 5000) timeouts++;
    if (n > 0) #(hold_ns);
    #(half_ns);
  endtask

  task automatic bit_io(input logic b, output logic s);
    #(half_ns / 4);
    sda_drv_o = b;
    #(half_ns - half_ns / 4);
    scl_high();
    s = sda_i;
    scl_drv_o = 1'b0;
  endtask

  task automatic start();
    sda_drv_o = 1'b1;
    scl_high();
    sda_drv_o = 1'b0;
    #(half_ns);
    scl_drv_o = 1'b0;
  endtask

  task automatic stop();
    #(half_ns / 4);
    sda_drv_o = 1'b0;
    #(half_ns - half_ns / 4);
    scl_high();
    sda_drv_o = 1'b1;
    #(half_ns);
  endtask

  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  task automatic byte_rd(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask
endmodule

/* tb/dual_port_i2c_target_tb.sv */
`timescale 1ns/1ns
module dual_port_i2c_target_tb;
  typedef struct {
    logic [1:0] lvl;
    logic       mm;
    logic [6:0] adr;
    logic       ack;
    logic       port;
  } dpit_row_t;

  logic        core_clk  = 1'b0;
  logic        link_clk  = 1'b0;
  logic        rst_b     = 1'b0;
  logic [1:0]  strap     = 2'h0;
  logic        mm        = 1'b0;
  logic [6:0]  m1        = 7'h00;
  logic [6:0]  o1        = 7'h00;
  logic [6:0]  m2        = 7'h00;
  logic [6:0]  o2        = 7'h00;
  logic        rx_ready  = 1'b0;
  logic        tx_valid  = 1'b0;
  logic [7:0]  tx_data   = 8'h00;
  logic        scl_drv;
  logic        sda_drv;
  logic        scl_oe;
  logic        sda_oe;
  logic        booted;
  logic        rx_valid;
  logic [1:0]  rx_kind;
  logic [7:0]  rx_data;
  logic        rx_port;
  logic        tx_req;
  logic        stop_o;
  logic        scl_oe_fx;
  logic        sda_oe_fx;
  logic        fx_valid;
  logic        fx_port;
  logic [1:0]  fx_seen   = 2'h0;
  wire logic   scl_w;
  wire logic   sda_w;
  logic [10:0] ev_q[$];
  logic [7:0]  tx_tbl[2] = '{8'h96, 8'h3C};
  logic        stretched = 1'b0;
  int          tx_idx    = -1;
  int          dly_cnt   = 0;
  int          resp_dly  = 2;
  int          n_stop    = 0;
  int          error_cnt = 0;
  int          n_tests   = 0;
  logic        ack;
  logic [7:0]  d;

  dpit_row_t rows[6] = '{
    '{2'h0, 1'b0, 7'h20, 1'b1, 1'b0},
    '{2'h3, 1'b0, 7'h27, 1'b1, 1'b1},
    '{2'h1, 1'b0, 7'h25, 1'b1, 1'b1},
    '{2'h1, 1'b0, 7'h21, 1'b1, 1'b0},
    '{2'h2, 1'b0, 7'h21, 1'b0, 1'b0},
    '{2'h0, 1'b1, 7'h20, 1'b0, 1'b0}
  };

  always #20 core_clk = ~core_clk;
  always #15 link_clk = ~link_clk;

  // Open drain with pull-up: released lines read high
  assign scl_w = scl_drv & ~scl_oe & ~scl_oe_fx;
  assign sda_w = sda_drv & ~sda_oe & ~sda_oe_fx;

  dpit_top #(.SECOND_TARGET_PORT(1'b0)) i_dpit_top (
    .core_clk_i                  (core_clk),
    .rst_b_i                     (rst_b),
    .link_clk_i                  (link_clk),
    .scl_i                       (scl_w),
    .scl_o                       (),
    .scl_oe_o                    (scl_oe),
    .sda_i                       (sda_w),
    .sda_o                       (),
    .sda_oe_o                    (sda_oe),
    .address_select_analog_pin_i (strap),
    .master_mode_i               (mm),
    .addr_mask_p1_i              (m1),
    .addr_ovr_p1_i               (o1),
    .addr_mask_p2_i              (m2),
    .addr_ovr_p2_i               (o2),
    .rx_ready_i                  (rx_ready),
    .tx_valid_i                  (tx_valid),
    .tx_data_i                   (tx_data),
    .booted_o                    (booted),
    .rx_valid_o                  (rx_valid),
    .rx_kind_o                   (rx_kind),
    .rx_data_o                   (rx_data),
    .rx_port_o                   (rx_port),
    .tx_req_o                    (tx_req),
    .stop_o                      (stop_o)
  );

  // Target-only interface with fixed addresses on the same bus
  dpit_top #(.SECOND_TARGET_PORT(1'b1)) i_dpit_top_fixed (
    .core_clk_i                  (core_clk),
    .rst_b_i                     (rst_b),
    .link_clk_i                  (link_clk),
    .scl_i                       (scl_w),
    .scl_o                       (),
    .scl_oe_o                    (scl_oe_fx),
    .sda_i                       (sda_w),
    .sda_o                       (),
    .sda_oe_o                    (sda_oe_fx),
    .address_select_analog_pin_i (strap),
    .master_mode_i               (mm),
    .addr_mask_p1_i              (7'h00),
    .addr_ovr_p1_i               (7'h00),
    .addr_mask_p2_i              (7'h00),
    .addr_ovr_p2_i               (7'h00),
    .rx_ready_i                  (rx_ready),
    .tx_valid_i                  (tx_valid),
    .tx_data_i                   (tx_data),
    .booted_o                    (),
    .rx_valid_o                  (fx_valid),
    .rx_kind_o                   (),
    .rx_data_o                   (),
    .rx_port_o                   (fx_port),
    .tx_req_o                    (),
    .stop_o                      ()
  );

  dpit_master_model i_dpit_master_model (
    .scl_i     (scl_w),
    .sda_i     (sda_w),
    .scl_drv_o (scl_drv),
    .sda_drv_o (sda_drv)
  );

  // User side: answers each event after resp_dly cycles
  always @(negedge core_clk) begin
    if (stop_o === 1'b1) n_stop++;
    if (scl_oe === 1'b1) stretched = 1'b1;
    if (fx_valid === 1'b1) fx_seen[fx_port] = 1'b1;
    if (rx_valid === 1'b1) begin
      ev_q.push_back({rx_kind, rx_port, rx_data});
      dly_cnt = resp_dly;
      if (rx_kind[0] === 1'b1) tx_idx++;
    end else if (dly_cnt > 0) begin
      dly_cnt--;
    end
    rx_ready = (dly_cnt == 0);
    tx_valid = (dly_cnt == 0) && (tx_req === 1'b1);
    if (tx_idx >= 0 && tx_idx < 2) tx_data = tx_tbl[tx_idx];
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic guard();
    chk(11'(i_dpit_master_model.timeouts), 11'h000, "bus hang");
    if (i_dpit_master_model.timeouts != 0) conclude();
  endtask

  task automatic ev_chk(input logic [1:0] k, input logic p, input logic [7:0] v);
    logic [10:0] e;
    e = 11'h7ff;
    if (ev_q.size() > 0) e = ev_q.pop_front();
    chk(e, {k, p, v}, "event");
  endtask

  task automatic do_reset(input logic [1:0] lv, input logic m,
                          input logic [6:0] a, input logic [6:0] b,
                          input logic [6:0] c, input logic [6:0] e);
    int n;
    @(negedge core_clk);
    rst_b = 1'b0;
    strap = lv;
    mm = m;
    m1 = a;
    o1 = b;
    m2 = c;
    o2 = e;
    repeat (20) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (10) @(negedge core_clk);
    chk(11'(booted), 11'h000, "booted too early");
    chk(11'(sda_oe), 11'h000, "sda driven before boot");
    n = 0;
    while (booted !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(11'(booted), 11'h001, "boot done");
    if (booted !== 1'b1) conclude();
    // Addresses still crossing to the link side
    repeat (50) @(negedge core_clk);
    ev_q.delete();
    n_stop = 0;
    stretched = 1'b0;
  endtask

  task automatic xfer_wr(input logic [6:0] a, input logic ea, input logic p);
    logic ak;
    i_dpit_master_model.start();
    i_dpit_master_model.byte_wr({a, 1'b0}, ak);
    chk(11'(ak), 11'(ea), "address ack");
    if (ea) begin
      i_dpit_master_model.byte_wr(8'h5A, ak);
      chk(11'(ak), 11'h001, "data ack");
    end
    i_dpit_master_model.stop();
    guard();
    repeat (20) @(negedge core_clk);
    if (ea) begin
      ev_chk(2'h0, p, {a, 1'b0});
      ev_chk(2'h2, p, 8'h5A);
    end
    chk(11'(ev_q.size()), 11'h000, "stray event");
  endtask

  initial begin
    for (int i = 0; i < 6; i++) begin
      do_reset(rows[i].lvl, rows[i].mm, 7'h00, 7'h00, 7'h00, 7'h00);
      xfer_wr(rows[i].adr, rows[i].ack, rows[i].port);
    end
    // Read with master ack then nack
    do_reset(2'h0, 1'b0, 7'h00, 7'h00, 7'h00, 7'h00);
    tx_idx = -1;
    i_dpit_master_model.start();
    i_dpit_master_model.byte_wr({7'h24, 1'b1}, ack);
    chk(11'(ack), 11'h001, "read address ack");
    i_dpit_master_model.byte_rd(1'b1, d);
    chk(11'(d), 11'h096, "first read byte");
    i_dpit_master_model.byte_rd(1'b0, d);
    chk(11'(d), 11'h03c, "last read byte");
    repeat (10) @(negedge core_clk);
    chk(11'(sda_oe), 11'h000, "sda held after nack");
    i_dpit_master_model.stop();
    guard();
    repeat (20) @(negedge core_clk);
    chk(11'(n_stop), 11'h001, "stop pulses");
    chk(11'(tx_req), 11'h000, "request left open");
    ev_chk(2'h1, 1'b1, {7'h24, 1'b1});
    // Read request event repeats the address byte
    ev_chk(2'h3, 1'b1, {7'h24, 1'b1});
    // Slow user at standard speed forces stretching
    i_dpit_master_model.half_ns = 5000;
    resp_dly = 100;
    do_reset(2'h0, 1'b0, 7'h00, 7'h00, 7'h00, 7'h00);
    xfer_wr(7'h20, 1'b1, 1'b0);
    chk(11'(stretched), 11'h001, "clock held low");
    i_dpit_master_model.half_ns = 1250;
    resp_dly = 2;
    // Full override on port 1, single bit on port 2
    do_reset(2'h1, 1'b0, 7'h7f, 7'h50, 7'h01, 7'h00);
    xfer_wr(7'h50, 1'b1, 1'b0);
    xfer_wr(7'h21, 1'b0, 1'b0);
    xfer_wr(7'h24, 1'b1, 1'b1);
    i_dpit_master_model.start();
    i_dpit_master_model.byte_wr({7'h38, 1'b0}, ack);
    chk(11'(ack), 11'h001, "fixed port 1 ack");
    i_dpit_master_model.stop();
    i_dpit_master_model.start();
    i_dpit_master_model.byte_wr({7'h3F, 1'b0}, ack);
    chk(11'(ack), 11'h001, "fixed port 2 ack");
    i_dpit_master_model.stop();
    guard();
    repeat (20) @(negedge core_clk);
    chk(11'(fx_seen), 11'h003, "fixed ports reached");
    chk(11'(ev_q.size()), 11'h000, "strap target took fixed address");
    conclude();
  end
endmodule
